// ===== pkg/pwm_timer_pkg.sv
// Package with register map, field layout and shared types of the PWM timer channel.
package pwm_timer_pkg;
  // Register indices; the byte address on the bus is four times the index.
  localparam logic [15:0] IDX_CTRL = 16'h5400;
  localparam logic [15:0] IDX_COUNT = 16'h5402;
  localparam logic [15:0] IDX_CCCTL = 16'h5404;
  localparam logic [15:0] IDX_DATA_A = 16'h5406;
  localparam logic [15:0] IDX_DATA_B = 16'h5408;
  // Field positions in the counter control register.
  localparam int unsigned CTL_MODE_BIT = 2;
  localparam int unsigned CTL_CLEAR_BIT = 1;
  localparam int unsigned CTL_RUN_BIT = 0;
  // Field positions in the compare/capture control register.
  localparam int unsigned CAPB_LSB = 14;
  localparam int unsigned OUTB_LSB = 12;
  localparam int unsigned POLB_BIT = 9;
  localparam int unsigned ROLEB_BIT = 8;
  localparam int unsigned CAPA_LSB = 6;
  localparam int unsigned OUTA_LSB = 4;
  localparam int unsigned POLA_BIT = 1;
  localparam int unsigned ROLEA_BIT = 0;
  // Capture edge encodings.
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  // Waveform mode encodings.
  localparam logic [1:0] OUT_OFF = 2'h0;
  localparam logic [1:0] OUT_SET_CLR = 2'h1;
  localparam logic [1:0] OUT_TGL_A = 2'h2;
  localparam logic [1:0] OUT_TGL_B = 2'h3;
  // Reset values and the count clock divider (pclk cycles per count tick).
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic [3:0] TICK_DIV = 4'h2;
  localparam logic [3:0] TICK_ONE = 4'h1;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;
  // Per-channel compare/capture settings.
  typedef struct packed {
    logic [1:0] edge_sel;
    logic [1:0] out_mode;
    logic polarity;
    logic capture_role;
  } chan_cfg_t;
  localparam chan_cfg_t CFG_RST = '{EDGE_NONE, OUT_OFF, 1'b0, 1'b0};
  // Run state of the counter.
  typedef enum logic {ST_STOPPED = 1'b0, ST_RUNNING = 1'b1} run_state_t;
endpackage

// ===== rtl/capture_trigger.sv
// Edge detector that fires a capture strobe on the selected edges of one input.
`timescale 1ns/1ns
module capture_trigger
  import pwm_timer_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Trigger pin and settings.
  input wire logic trig_in,
  input wire logic [1:0] edge_sel,
  input wire logic active,
  // Capture strobe, one pclk cycle.
  output logic fire
);
  logic prev_r; // Pin level one cycle ago.
  logic prev_nxt;
  logic rise;
  logic fall;

  // Edge decode; the pin is already synchronous so no synchroniser is needed.
  always_comb
  begin
    prev_nxt = trig_in;
    rise = trig_in & ~prev_r;
    fall = ~trig_in & prev_r;
    fire = active & ((rise & ((edge_sel == EDGE_RISE) | (edge_sel == EDGE_BOTH))) |
                     (fall & ((edge_sel == EDGE_FALL) | (edge_sel == EDGE_BOTH))));
  end

  // Pin history.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prev_r <= 1'b0;
    else
      prev_r <= prev_nxt;
  end
endmodule

// ===== rtl/pwm_timer_count_capture_ctrl.sv
// One 16-bit PWM timer channel: counter, compare/capture and APB registers.
// Overview of operation
// RULE1: Repeat mode counts until software stops it.
// RULE2: One-shot mode stops on compare B.
// RULE3: Clear bit write one zeroes counter.
// RULE4: Run bit starts, stops, reads run state.
// RULE5: Stopping keeps counter value for resume.
// RULE6: Counter value readable anytime, resets zero.
// RULE7: Software reads counter in one access.
// RULE8: Capture B edge select chooses trigger edges.
// RULE9: Capture B edges ignored in comparator role.
// RULE10: Output B mode selects waveform behaviour.
// RULE11: Output B mode ignored in capture role.
// RULE12: Output B polarity sets active level.
// RULE13: Output B polarity ignored in capture role.
// RULE14: Data B role bit selects capture.
// RULE15: Capture A edge select chooses edges.
// RULE16: Output A mode selects waveform behaviour.
// RULE17: Output A polarity sets active level.
// RULE18: Data A role bit selects capture.
// RULE19: Counter increments; compare B wraps to zero.
// RULE20: Reserved control bits read zero.
`timescale 1ns/1ns
module pwm_timer_count_capture_ctrl
  import pwm_timer_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Capture trigger pins.
  input wire logic capture_a_input,
  input wire logic capture_b_input,
  // Waveform pins.
  output logic wave_out_a,
  output logic wave_out_b
);
  // True when the word address matches a register index.
  function automatic logic addr_hit(input logic [31:0] addr, input logic [15:0] idx);
    addr_hit = (addr[31:18] == 14'h0000) && (addr[1:0] == 2'h0) && (addr[17:2] == idx);
  endfunction

  // Control state.
  run_state_t run_st_r; // Counting or stopped.
  run_state_t run_st_nxt;
  logic mode_r; // Count mode select: one-shot when set.
  logic mode_nxt;
  logic [15:0] count_r; // Counter value.
  logic [15:0] count_nxt;
  logic [3:0] div_r; // Count clock divider.
  logic [3:0] div_nxt;
  logic tick; // One-cycle count clock enable.
  // Compare/capture state.
  chan_cfg_t cfg_a_r;
  chan_cfg_t cfg_a_nxt;
  chan_cfg_t cfg_b_r;
  chan_cfg_t cfg_b_nxt;
  logic [15:0] data_a_r;
  logic [15:0] data_a_nxt;
  logic [15:0] data_b_r;
  logic [15:0] data_b_nxt;
  // Bus state.
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic pslverr_r;
  logic pslverr_nxt;
  // Decoded strobes and events.
  logic setup;
  logic wr_en;
  logic ctrl_we;
  logic hit_a;
  logic hit_b;
  logic cap_a_fire;
  logic cap_b_fire;
  logic mapped;
  logic [31:0] rd_val;

  // Bus strobes; writes land on the access cycle, which never waits.
  always_comb
  begin
    setup = psel & ~penable;
    wr_en = psel & penable & pwrite;
    ctrl_we = wr_en & addr_hit(paddr, IDX_CTRL);
  end

  // Count clock divider; only one clock exists, so the rate is an enable.
  always_comb
  begin
    tick = (div_r == TICK_ONE);
    div_nxt = tick ? TICK_DIV : div_r - TICK_ONE;
  end

  // Compare events only in comparator role and only on a running tick.
  always_comb
  begin
    hit_a = tick & (run_st_r == ST_RUNNING) & ~cfg_a_r.capture_role & (count_r == data_a_r);
    hit_b = tick & (run_st_r == ST_RUNNING) & ~cfg_b_r.capture_role & (count_r == data_b_r);
  end

  // Capture units, active only in capture role.
  capture_trigger u_cap_a (
    .pclk(pclk),
    .presetn(presetn),
    .trig_in(capture_a_input),
    .edge_sel(cfg_a_r.edge_sel),
    .active(cfg_a_r.capture_role), // RULE15 RULE18
    .fire(cap_a_fire)
  );
  capture_trigger u_cap_b (
    .pclk(pclk),
    .presetn(presetn),
    .trig_in(capture_b_input),
    .edge_sel(cfg_b_r.edge_sel),
    .active(cfg_b_r.capture_role), // RULE8 RULE9 RULE14
    .fire(cap_b_fire)
  );

  // Waveform units, silenced while their data register captures.
  wave_output u_wave_a (
    .pclk(pclk),
    .presetn(presetn),
    .out_mode(cfg_a_r.out_mode),
    .polarity(cfg_a_r.polarity),
    .active(~cfg_a_r.capture_role),
    .hit_a(hit_a),
    .hit_b(hit_b),
    .wave(wave_out_a)
  );
  wave_output u_wave_b (
    .pclk(pclk),
    .presetn(presetn),
    .out_mode(cfg_b_r.out_mode),
    .polarity(cfg_b_r.polarity),
    .active(~cfg_b_r.capture_role), // RULE11 RULE13
    .hit_a(hit_a),
    .hit_b(hit_b),
    .wave(wave_out_b)
  );

  // Counter and run state next values.
  always_comb
  begin
    run_st_nxt = run_st_r;
    mode_nxt = mode_r;
    count_nxt = count_r;
    // Counting; stopped holds the value for a later resume.
    if (tick && (run_st_r == ST_RUNNING))
      count_nxt = hit_b ? COUNT_RST : count_r + 16'h0001; // RULE19 RULE5
    // In one-shot mode compare B ends the run; repeat mode keeps going.
    if (hit_b && mode_r)
      run_st_nxt = ST_STOPPED; // RULE2 RULE1
    if (ctrl_we)
    begin
      // A software write comes later than the event, so it decides.
      mode_nxt = pwdata[CTL_MODE_BIT];
      run_st_nxt = run_state_t'(pwdata[CTL_RUN_BIT]); // RULE4
      if (pwdata[CTL_CLEAR_BIT])
        count_nxt = COUNT_RST; // RULE3
    end
  end

  // Compare/capture configuration and data next values.
  always_comb
  begin
    cfg_a_nxt = cfg_a_r;
    cfg_b_nxt = cfg_b_r;
    data_a_nxt = data_a_r;
    data_b_nxt = data_b_r;
    if (wr_en && addr_hit(paddr, IDX_CCCTL))
    begin
      // Reserved bits are simply not stored.
      cfg_b_nxt = '{pwdata[CAPB_LSB +: 2], pwdata[OUTB_LSB +: 2], pwdata[POLB_BIT],
                    pwdata[ROLEB_BIT]}; // RULE14 RULE20
      cfg_a_nxt = '{pwdata[CAPA_LSB +: 2], pwdata[OUTA_LSB +: 2], pwdata[POLA_BIT],
                    pwdata[ROLEA_BIT]}; // RULE18 RULE20
    end
    if (wr_en && addr_hit(paddr, IDX_DATA_A))
      data_a_nxt = pwdata[15:0];
    if (wr_en && addr_hit(paddr, IDX_DATA_B))
      data_b_nxt = pwdata[15:0];
    // A capture wins over a write in the same cycle so no edge is lost.
    if (cap_a_fire)
      data_a_nxt = count_r; // RULE15 RULE18
    if (cap_b_fire)
      data_b_nxt = count_r; // RULE8
  end

  // Read mux; reserved and write-only bits read as zero.
  always_comb
  begin
    rd_val = RD_ZERO;
    mapped = 1'b1;
    if (addr_hit(paddr, IDX_CTRL))
    begin
      rd_val[CTL_MODE_BIT] = mode_r;
      rd_val[CTL_RUN_BIT] = run_st_r; // RULE4 RULE3
    end
    else if (addr_hit(paddr, IDX_COUNT))
      rd_val[15:0] = count_r; // RULE6
    else if (addr_hit(paddr, IDX_CCCTL))
    begin
      rd_val[CAPB_LSB +: 2] = cfg_b_r.edge_sel;
      rd_val[OUTB_LSB +: 2] = cfg_b_r.out_mode;
      rd_val[POLB_BIT] = cfg_b_r.polarity;
      rd_val[ROLEB_BIT] = cfg_b_r.capture_role;
      rd_val[CAPA_LSB +: 2] = cfg_a_r.edge_sel;
      rd_val[OUTA_LSB +: 2] = cfg_a_r.out_mode;
      rd_val[POLA_BIT] = cfg_a_r.polarity;
      rd_val[ROLEA_BIT] = cfg_a_r.capture_role; // RULE20
    end
    else if (addr_hit(paddr, IDX_DATA_A))
      rd_val[15:0] = data_a_r;
    else if (addr_hit(paddr, IDX_DATA_B))
      rd_val[15:0] = data_b_r;
    else
      mapped = 1'b0;
    // Read data is sampled in the setup cycle and held for the access cycle.
    prdata_nxt = setup ? (pwrite ? RD_ZERO : rd_val) : prdata_r;
    pslverr_nxt = setup ? ~mapped : pslverr_r;
  end

  // All state registers.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      run_st_r <= ST_STOPPED;
      mode_r <= 1'b0;
      count_r <= COUNT_RST;
      div_r <= TICK_DIV;
      cfg_a_r <= CFG_RST;
      cfg_b_r <= CFG_RST;
      data_a_r <= DATA_RST;
      data_b_r <= DATA_RST;
      prdata_r <= RD_ZERO;
      pslverr_r <= 1'b0;
    end
    else
    begin
      run_st_r <= run_st_nxt;
      mode_r <= mode_nxt;
      count_r <= count_nxt;
      div_r <= div_nxt;
      cfg_a_r <= cfg_a_nxt;
      cfg_b_r <= cfg_b_nxt;
      data_a_r <= data_a_nxt;
      data_b_r <= data_b_nxt;
      prdata_r <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // Zero wait states; the error only shows in the access cycle.
  assign pready = psel & penable;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r & psel & penable;

  // Checks that guard the counter, captures, outputs and register reads.
  a_clear_zeroes: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_we && pwdata[CTL_CLEAR_BIT] |=> count_r == COUNT_RST) // RULE3
    else $error("Clear write did not zero the counter.");
  a_stop_holds: assert property (@(posedge pclk) disable iff (!presetn)
    run_st_r == ST_STOPPED && !ctrl_we |=> $stable(count_r)) // RULE5
    else $error("Stopped counter changed.");
  a_oneshot_stop: assert property (@(posedge pclk) disable iff (!presetn)
    hit_b && mode_r && !ctrl_we |=> run_st_r == ST_STOPPED ##1 $stable(count_r)) // RULE2
    else $error("One-shot counter kept running.");
  a_repeat_runs: assert property (@(posedge pclk) disable iff (!presetn)
    run_st_r == ST_RUNNING && !mode_r && !ctrl_we |=> run_st_r == ST_RUNNING) // RULE1
    else $error("Repeat mode counter stopped itself.");
  a_count_step: assert property (@(posedge pclk) disable iff (!presetn)
    tick && run_st_r == ST_RUNNING && !hit_b && !ctrl_we
    |=> count_r == $past(count_r) + 16'h0001) // RULE19
    else $error("Counter did not step by one.");
  a_cmpb_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    hit_b && !ctrl_we |=> count_r == COUNT_RST) // RULE19
    else $error("Compare B did not wrap the counter.");
  a_capture_b_load: assert property (@(posedge pclk) disable iff (!presetn)
    cap_b_fire |=> data_b_r == $past(count_r)) // RULE8
    else $error("Capture B did not load the counter.");
  a_capb_ignored: assert property (@(posedge pclk) disable iff (!presetn)
    !cfg_b_r.capture_role |-> !cap_b_fire) // RULE9
    else $error("Capture B fired in comparator role.");
  a_outb_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    cfg_b_r.capture_role [*2] |-> !wave_out_b) // RULE11
    else $error("Output B moved in capture role.");
  a_run_readback: assert property (@(posedge pclk) disable iff (!presetn)
    setup && !pwrite && addr_hit(paddr, IDX_CTRL)
    |=> prdata_r[CTL_RUN_BIT] == $past(run_st_r) && !prdata_r[CTL_CLEAR_BIT]) // RULE4
    else $error("Run bit read back wrong.");
  a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
    setup && !pwrite && addr_hit(paddr, IDX_CCCTL)
    |=> prdata_r[11:10] == 2'h0 && prdata_r[3:2] == 2'h0 && prdata_r[31:16] == 16'h0000) // RULE20
    else $error("Reserved control bits read nonzero.");
endmodule

// ===== rtl/wave_output.sv
// Waveform generator for one timer output driven by the compare A and B events.
`timescale 1ns/1ns
module wave_output
  import pwm_timer_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Settings; active is low while the data register is in capture role.
  input wire logic [1:0] out_mode,
  input wire logic polarity,
  input wire logic active,
  // Compare events.
  input wire logic hit_a,
  input wire logic hit_b,
  // Pin level.
  output logic wave
);
  logic state_r; // Active-high internal waveform.
  logic state_nxt;
  logic wave_r;
  logic wave_nxt;

  // Next waveform state from mode and events.
  always_comb
  begin
    state_nxt = state_r;
    if (!active)
      state_nxt = 1'b0; // RULE11
    else
      unique case (out_mode)
        OUT_OFF: state_nxt = 1'b0; // RULE10 RULE16
        OUT_SET_CLR:
        begin
          // B clears after A sets, so a tie ends the pulse.
          if (hit_a)
            state_nxt = 1'b1; // RULE10 RULE16
          if (hit_b)
            state_nxt = 1'b0; // RULE10 RULE16
        end
        OUT_TGL_A: state_nxt = state_r ^ hit_a; // RULE10 RULE16
        OUT_TGL_B: state_nxt = state_r ^ hit_b; // RULE10 RULE16
      endcase
    // Polarity sets the off level; in capture role the pin sits low.
    wave_nxt = active ? (state_nxt ^ polarity) : 1'b0; // RULE12 RULE17 RULE13
  end

  // Waveform and pin registers.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= 1'b0;
      wave_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      wave_r <= wave_nxt;
    end
  end

  assign wave = wave_r;
endmodule

// ===== verif/tb.sv
// Self-checking bench for the PWM timer channel: registers, counting, captures, waveforms.
`timescale 1ns/1ns
module tb;
  import pwm_timer_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic pready;
  logic [31:0] prdata;
  logic pslverr;
  logic cap_a = 1'b0;
  logic cap_b = 1'b0;
  logic wave_a;
  logic wave_b;
  logic err_seen;
  logic [31:0] q;
  logic [31:0] c;
  int failures = 0;
  int checked = 0;
  int cyc = 0;
  // Edge counts taken on the waveform pins over one observation window.
  int rise_a;
  int rise_b;
  int flip_a;
  int flip_b;

  pwm_timer_count_capture_ctrl pwm_timer_count_capture_ctrl_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .capture_a_input(cap_a), .capture_b_input(cap_b),
    .wave_out_a(wave_a), .wave_out_b(wave_b)
  );

  // The clock toggles every 10 ns, half of its 20 ns period.
  initial
  begin
    forever #10 pclk = ~pclk;
  end

  // Compares a seen value with the expected one and counts the outcome.
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One APB transfer; the request stands until pready is sampled high.
  task automatic xfer(input logic w, input logic [15:0] idx, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {14'h0, idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    xfer(1'b1, idx, d);
  endtask

  // Register read; the word read lands in q.
  task automatic rd(input logic [15:0] idx);
    xfer(1'b0, idx, 32'h0);
  endtask

  // Counts rises and changes of both waveform pins, sampled just after each edge.
  task automatic watch(input int n);
    logic pa;
    logic pb;
    pa = wave_a;
    pb = wave_b;
    rise_a = 0;
    rise_b = 0;
    flip_a = 0;
    flip_b = 0;
    repeat (n)
    begin
      @(posedge pclk);
      #1;
      if (wave_a === 1'b1 && pa === 1'b0)
        rise_a++;
      if (wave_b === 1'b1 && pb === 1'b0)
        rise_b++;
      if (wave_a !== pa)
        flip_a++;
      if (wave_b !== pb)
        flip_b++;
      pa = wave_a;
      pb = wave_b;
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    $display("comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // A hang is cut short well beyond the expected run length.
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      failures++;
      results();
    end
  end

  initial
  begin
    tick(4);
    presetn <= 1'b1;
    tick(2);
    // Reset values of the control, count and compare/capture control registers.
    rd(IDX_CTRL);
    chk("ctrl rst", q, 32'h0);
    rd(IDX_COUNT);
    chk("count rst", q, 32'h0);
    rd(IDX_CCCTL);
    chk("ccctl rst", q, 32'h0);
    // Reserved bits are not stored; an unmapped place reads zero with an error.
    wr(IDX_CCCTL, 32'hffff_ffff);
    rd(IDX_CCCTL);
    chk("ccctl rsvd", q, 32'h0000_f3f3);
    wr(16'h5410, 32'h1234);
    chk("unmapped err", {31'h0, err_seen}, 32'h1);
    rd(16'h5410);
    chk("unmapped rd", q, 32'h0);
    wr(IDX_CCCTL, 32'h0);
    $display("test registers done");
    // Repeat mode keeps counting and wraps on compare B.
    wr(IDX_DATA_B, 32'h5);
    wr(IDX_CTRL, 32'h1);
    tick(60);
    rd(IDX_CTRL);
    chk("run state", q, 32'h1);
    wr(IDX_CTRL, 32'h0);
    rd(IDX_COUNT);
    c = q;
    chk("count bound", {31'h0, c <= 32'h5}, 32'h1);
    tick(10);
    rd(IDX_COUNT);
    chk("count held", q, c);
    wr(IDX_CTRL, 32'h2);
    rd(IDX_COUNT);
    chk("count clear", q, 32'h0);
    rd(IDX_CTRL);
    chk("clear reads 0", q, 32'h0);
    $display("test repeat done");
    // One-shot mode stops itself on compare B with the counter back at zero.
    wr(IDX_DATA_B, 32'h3);
    wr(IDX_CTRL, 32'h5);
    tick(40);
    rd(IDX_CTRL);
    chk("oneshot stop", q, 32'h4);
    rd(IDX_COUNT);
    chk("oneshot count", q, 32'h0);
    $display("test oneshot done");
    // Both data registers in capture role; a stopped counter gives a known value.
    wr(IDX_CCCTL, 32'h0101);
    wr(IDX_CTRL, 32'h2);
    wr(IDX_CTRL, 32'h1);
    tick(20);
    wr(IDX_CTRL, 32'h0);
    rd(IDX_COUNT);
    c = q;
    chk("count rate", {31'h0, c >= 32'd9 && c <= 32'd13}, 32'h1);
    for (int s = 0; s < 4; s++)
    begin
      wr(IDX_CCCTL, (s << 14) | (s << 6) | 32'h0101);
      wr(IDX_DATA_A, 32'haaaa);
      wr(IDX_DATA_B, 32'haaaa);
      cap_a <= 1'b1;
      cap_b <= 1'b1;
      tick(3);
      rd(IDX_DATA_A);
      chk("cap a rise", q, s[0] ? c : 32'haaaa);
      rd(IDX_DATA_B);
      chk("cap b rise", q, s[0] ? c : 32'haaaa);
      wr(IDX_DATA_A, 32'haaaa);
      wr(IDX_DATA_B, 32'haaaa);
      cap_a <= 1'b0;
      cap_b <= 1'b0;
      tick(3);
      rd(IDX_DATA_A);
      chk("cap a fall", q, s[1] ? c : 32'haaaa);
      rd(IDX_DATA_B);
      chk("cap b fall", q, s[1] ? c : 32'haaaa);
    end
    // Edge selects do nothing in comparator role; the marker differs from any capture.
    wr(IDX_CCCTL, 32'hc0c0);
    wr(IDX_DATA_B, 32'haaaa);
    cap_b <= 1'b1;
    tick(3);
    rd(IDX_DATA_B);
    chk("cmp no cap", q, 32'haaaa);
    cap_b <= 1'b0;
    $display("test capture done");
    // Off levels follow polarity in comparator role; capture role ignores polarity.
    wr(IDX_CCCTL, 32'h0200);
    tick(3);
    chk("b off inv", {31'h0, wave_b}, 32'h1);
    chk("a off", {31'h0, wave_a}, 32'h0);
    wr(IDX_CCCTL, 32'h3300);
    tick(3);
    chk("b capture", {31'h0, wave_b}, 32'h0);
    // A sets on compare A and clears on B; B toggles on compare A.
    wr(IDX_CCCTL, 32'h2210);
    wr(IDX_DATA_A, 32'h2);
    wr(IDX_DATA_B, 32'h6);
    wr(IDX_CTRL, 32'h2);
    wr(IDX_CTRL, 32'h1);
    // A period is seven ticks, so this window holds exactly ten events of each compare.
    watch(142);
    chk("a set pulses", rise_a, 32'd10);
    chk("b toggles on a", flip_b, 32'd10);
    // A toggles on compare B; B sets on compare A and clears on B.
    wr(IDX_CTRL, 32'h0);
    wr(IDX_CCCTL, 32'h0101);
    wr(IDX_CCCTL, 32'h1030);
    wr(IDX_CTRL, 32'h3);
    watch(142);
    chk("a toggles on b", flip_a, 32'd10);
    chk("b set pulses", rise_b, 32'd10);
    $display("test waveform done");
    results();
  end
endmodule
